/* src/mon_pcs_params.svh */
// register offsets, field positions, reset values and timing for the monitor and pcs control bank
// assumes inclusion by bare name from the register bank, the checks and the testbench
`ifndef MON_PCS_PARAMS_SVH
`define MON_PCS_PARAMS_SVH

`define TEMP_STAT_IDX      16'h0483
`define SUPPLY_STAT_IDX    16'h0484
`define PCS_CTRL_IDX       16'h0485
`define RUN_CFG_IDX        16'h0481
`define RUN_CYCLE_IDX      16'h0480
`define TEMP_LSB           0
`define TEMP_MSB           2
`define ANA_LSB            8
`define ANA_MSB            10
`define IO_LSB             12
`define IO_MSB             14
`define IDLE_LSB           0
`define IDLE_MSB           8
`define LINK_CTRL_BIT      12
`define IPG_DIS_BIT        13
`define RUN_START_BIT      0
`define RUN_PERIODIC_BIT   1
`define IDLE_CNT_RST       9'h078
`define CODE_RST           3'h0
`define RUN_CYCLE_RST      4'h0
`define CYCLE_UNIT_NS      1000
`define CLK_PERIOD_NS      10
`define MEAS_CYCLES        4'h8
`define RUN_TIMER_W        24
`define CYCLE_LSB          0
`define CYCLE_MSB          3
`define WORD_IDX_LSB       2
`define WORD_IDX_MSB       17

`endif

/* src/mon_pcs_pkg.sv */
// types shared by the monitor and pcs control bank
// assumes field widths here match the field positions in mon_pcs_params.svh
package mon_pcs_pkg;
    typedef struct packed {
        logic [2:0] temp_code;
        logic [2:0] analog_code;
        logic [2:0] io_code;
    } sensor_codes_s;

    typedef struct packed {
        logic       link_enable;
        logic       ipg_check_enable;
        logic [8:0] lock_idle_count;
    } pcs_control_s;

    typedef enum logic [1:0] {
        RUN_IDLE = 2'b00,
        RUN_MEAS = 2'b01,
        RUN_WAIT = 2'b10
    } run_state_e;
endpackage : mon_pcs_pkg

/* src/idle_lock_counter.sv */
// counts received idle symbols and declares descrambler lock
// assumes idle_symbol is a one-cycle strobe on clk_sys from the pcs receive path
`timescale 1ns/1ps
`default_nettype none
module idle_lock_counter #(
    parameter int CW = 9
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rst,
    // control
    input  wire logic          enable,
    input  wire logic [CW-1:0] threshold,
    input  wire logic          idle_symbol,
    input  wire logic          error_symbol,
    // status
    output logic               locked
);
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic          next_locked;

    always_comb begin
        next_count  = count;
        next_locked = locked;
        if (!enable || error_symbol) begin
            next_count  = '0;
            next_locked = 1'b0;
        end else if (idle_symbol && !locked) begin
            if (count + CW'(1) >= threshold) begin
                next_locked = 1'b1;
            end
            next_count = count + CW'(1);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count  <= '0;
            locked <= 1'b0;
        end else begin
            count  <= next_count;
            locked <= next_locked;
        end
    end
endmodule : idle_lock_counter
`default_nettype wire

/* src/mon_pcs_regs.sv */
// monitor status and pcs control register bank, ahb-lite slave, 16-bit registers in low half
// assumes single-word transfers, symbol strobes and all other pcs inputs from the clk_sys domain
// except sensor codes, which come from analog and are synchronised here
`include "mon_pcs_params.svh"
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - The temperature band code is read-only in bits 2:0, resets to 000, higher codes mean hotter.
// - The analog supply band code is read-only in bits 10:8, higher codes mean lower voltage.
// - The io supply band code is read-only in bits 14:12 and resets to 000.
// - Setting bit 13 turns off scrambler lock checking during the inter-packet gap.
// - Training and link-up may start only while bit 12 is 1, its reset value.
// - Lock and link are declared only after the idle count in bits 8:0 (reset 120) is received.
// - Writing 1 to the start bit begins a measurement and the bit clears itself once accepted.
// - Periodic mode repeats measurements at the configured cycle time, otherwise one run per start.
module mon_pcs_regs #(
    parameter int TIMER_W = `RUN_TIMER_W
) (
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    // ahb-lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic                      hready,
    input  wire logic [31:0]               hwdata,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    // analog sensor codes, asynchronous
    input  wire mon_pcs_pkg::sensor_codes_s sensor_raw,
    // pcs receive path
    input  wire logic                      idle_symbol,
    input  wire logic                      error_symbol,
    input  wire logic                      ipg_active,
    input  wire logic                      lock_check_fail,
    // to pcs and analog
    output mon_pcs_pkg::pcs_control_s      pcs_ctrl,
    output logic                           sample_req,
    output logic                           link_up,
    output logic                           lock_lost
);
    import mon_pcs_pkg::*;

    sensor_codes_s sync1, sync2, results, next_results;
    logic          ipg_dis, next_ipg_dis, link_en, next_link_en;
    logic [8:0]    idle_cnt, next_idle_cnt;
    logic          periodic, next_periodic, start, next_start;
    logic [3:0]    cycle_sel, next_cycle_sel;
    run_state_e    state, next_state;
    logic [TIMER_W-1:0] timer, next_timer;
    logic          next_sample_req;
    logic          wr_pend, next_wr_pend;
    logic [15:0]   wr_idx, next_wr_idx;
    logic [31:0]   next_hrdata;
    pcs_control_s  next_pcs_ctrl;
    logic          locked, next_link_up, next_lock_lost;

    function automatic logic [15:0] word_index(input logic [31:0] a);
        word_index = a[`WORD_IDX_MSB:`WORD_IDX_LSB];
    endfunction : word_index

    // period in cycles for a 4-bit cycle setting, in units of CYCLE_UNIT_NS
    function automatic logic [TIMER_W-1:0] period_cycles(input logic [3:0] sel);
        period_cycles = TIMER_W'((32'(sel) + 32'd1) * (`CYCLE_UNIT_NS / `CLK_PERIOD_NS));
    endfunction : period_cycles

    wire logic take = hsel && hready && htrans[1];

    // sensor codes cross from the analog domain
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= sensor_raw;
            sync2 <= sync1;
        end
    end

    // register writes: address latched in address phase, data applied in data phase
    always_comb begin
        next_wr_pend   = take && hwrite;
        next_wr_idx    = take ? word_index(haddr) : wr_idx;
        next_ipg_dis   = ipg_dis;
        next_link_en   = link_en;
        next_idle_cnt  = idle_cnt;
        next_periodic  = periodic;
        next_cycle_sel = cycle_sel;
        next_start     = start;
        if (state == RUN_IDLE && start) begin
            next_start = 1'b0;
        end
        if (wr_pend) begin
            unique case (wr_idx)
                `PCS_CTRL_IDX: begin
                    next_ipg_dis  = hwdata[`IPG_DIS_BIT];
                    next_link_en  = hwdata[`LINK_CTRL_BIT];
                    next_idle_cnt = hwdata[`IDLE_MSB:`IDLE_LSB];
                end
                `RUN_CFG_IDX: begin
                    next_periodic = hwdata[`RUN_PERIODIC_BIT];
                    if (hwdata[`RUN_START_BIT]) begin
                        next_start = 1'b1;
                    end
                end
                `RUN_CYCLE_IDX: begin
                    next_cycle_sel = hwdata[`CYCLE_MSB:`CYCLE_LSB];
                end
                default: begin
                    // status registers and unmapped words ignore writes
                    next_start = next_start;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_pend   <= 1'b0;
            wr_idx    <= '0;
            ipg_dis   <= 1'b0;
            link_en   <= 1'b1;
            idle_cnt  <= `IDLE_CNT_RST;
            periodic  <= 1'b1;
            cycle_sel <= `RUN_CYCLE_RST;
            start     <= 1'b0;
        end else begin
            wr_pend   <= next_wr_pend;
            wr_idx    <= next_wr_idx;
            ipg_dis   <= next_ipg_dis;
            link_en   <= next_link_en;
            idle_cnt  <= next_idle_cnt;
            periodic  <= next_periodic;
            cycle_sel <= next_cycle_sel;
            start     <= next_start;
        end
    end

    // measurement sequencer
    always_comb begin
        next_state      = state;
        next_timer      = timer;
        next_results    = results;
        next_sample_req = 1'b0;
        unique case (state)
            RUN_IDLE: begin
                if (start) begin
                    next_state      = RUN_MEAS;
                    next_timer      = TIMER_W'(`MEAS_CYCLES);
                    next_sample_req = 1'b1;
                end
            end
            RUN_MEAS: begin
                next_sample_req = 1'b1;
                if (timer == '0) begin
                    next_results    = sync2;
                    next_sample_req = 1'b0;
                    if (periodic) begin
                        next_state = RUN_WAIT;
                        next_timer = period_cycles(cycle_sel);
                    end else begin
                        next_state = RUN_IDLE;
                    end
                end else begin
                    next_timer = timer - TIMER_W'(1);
                end
            end
            RUN_WAIT: begin
                if (!periodic) begin
                    next_state = RUN_IDLE;
                end else if (timer == '0) begin
                    next_state      = RUN_MEAS;
                    next_timer      = TIMER_W'(`MEAS_CYCLES);
                    next_sample_req = 1'b1;
                end else begin
                    next_timer = timer - TIMER_W'(1);
                end
            end
            default: begin
                next_state = RUN_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state      <= RUN_IDLE;
            timer      <= '0;
            results    <= '0;
            sample_req <= 1'b0;
        end else begin
            state      <= next_state;
            timer      <= next_timer;
            results    <= next_results;
            sample_req <= next_sample_req;
        end
    end

    idle_lock_counter #(
        .CW(`IDLE_MSB - `IDLE_LSB + 1)
    ) u_lock (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .enable       (link_en),
        .threshold    (idle_cnt),
        .idle_symbol  (idle_symbol),
        .error_symbol (error_symbol),
        .locked       (locked)
    );

    // read data, pcs outputs and lock-check monitor
    always_comb begin
        next_hrdata = '0;
        if (take && !hwrite) begin
            unique case (word_index(haddr))
                `TEMP_STAT_IDX:   next_hrdata[`TEMP_MSB:`TEMP_LSB] = results.temp_code;
                `SUPPLY_STAT_IDX: begin
                    next_hrdata[`ANA_MSB:`ANA_LSB] = results.analog_code;
                    next_hrdata[`IO_MSB:`IO_LSB]   = results.io_code;
                end
                `PCS_CTRL_IDX: begin
                    next_hrdata[`IPG_DIS_BIT]        = ipg_dis;
                    next_hrdata[`LINK_CTRL_BIT]      = link_en;
                    next_hrdata[`IDLE_MSB:`IDLE_LSB] = idle_cnt;
                end
                `RUN_CFG_IDX: begin
                    next_hrdata[`RUN_PERIODIC_BIT] = periodic;
                    next_hrdata[`RUN_START_BIT]    = start;
                end
                `RUN_CYCLE_IDX:   next_hrdata[`CYCLE_MSB:`CYCLE_LSB] = cycle_sel;
                default:          next_hrdata = '0;
            endcase
        end
        next_pcs_ctrl.link_enable      = link_en;
        next_pcs_ctrl.ipg_check_enable = !ipg_dis;
        next_pcs_ctrl.lock_idle_count  = idle_cnt;
        next_link_up   = locked && link_en;
        next_lock_lost = lock_check_fail && (!ipg_active || !ipg_dis);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            pcs_ctrl  <= '{link_enable: 1'b1, ipg_check_enable: 1'b1,
                           lock_idle_count: `IDLE_CNT_RST};
            link_up   <= 1'b0;
            lock_lost <= 1'b0;
        end else begin
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            pcs_ctrl  <= next_pcs_ctrl;
            link_up   <= next_link_up;
            lock_lost <= next_lock_lost;
        end
    end
endmodule : mon_pcs_regs
`default_nettype wire

/* tb/mon_pcs_props.sv */
// concurrent checks on the monitor and pcs control bank, bound to mon_pcs_regs
// assumes the register index sits in haddr[17:2] and hready follows hreadyout
`include "mon_pcs_params.svh"
`timescale 1ns/1ps
`default_nettype none
module mon_pcs_props (
    // clock and reset
    input wire logic                      clk_sys,
    input wire logic                      rst,
    // bus
    input wire logic                      hsel,
    input wire logic [31:0]               haddr,
    input wire logic [1:0]                htrans,
    input wire logic                      hwrite,
    input wire logic                      hready,
    input wire logic [31:0]               hrdata,
    // pcs and analog side
    input wire logic                      ipg_active,
    input wire logic                      lock_check_fail,
    input wire mon_pcs_pkg::pcs_control_s pcs_ctrl,
    input wire logic                      sample_req,
    input wire logic                      link_up,
    input wire logic                      lock_lost
);
    import mon_pcs_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic take_rd;
    assign take_rd = hsel && hready && htrans[1] && !hwrite;
    sequence rd_of(logic [15:0] idx);
        take_rd && haddr[17:2] == idx;
    endsequence
    // nine sampling cycles, the longest repetition kept short for the tools
    sequence meas_run;
        sample_req [*8] ##1 sample_req;
    endsequence
    a_temp_rsvd: assert property (rd_of(`TEMP_STAT_IDX) |=> hrdata[15:3] == 13'h0)
        else $error("temperature word has reserved bits set");
    a_supply_rsvd: assert property (rd_of(`SUPPLY_STAT_IDX) |=>
        hrdata[15] == 1'b0 && hrdata[11:0] == 12'h0)
        else $error("supply word has reserved bits set");
    a_ctrl_readback: assert property (rd_of(`PCS_CTRL_IDX) |=>
        hrdata[13:12] == {!pcs_ctrl.ipg_check_enable, pcs_ctrl.link_enable}
        && hrdata[8:0] == pcs_ctrl.lock_idle_count)
        else $error("pcs control read disagrees with pcs_ctrl");
    a_lost_gated: assert property ((lock_check_fail && ipg_active) ##1
        !pcs_ctrl.ipg_check_enable |-> !lock_lost)
        else $error("lock loss flagged inside gap with check disabled");
    a_lost_outside: assert property (lock_check_fail && !ipg_active |=> lock_lost)
        else $error("lock check miss outside gap not flagged");
    a_link_off: assert property (!pcs_ctrl.link_enable |=> !link_up)
        else $error("link up while link control is off");
    a_link_rise: assert property ($rose(link_up) |-> $past(pcs_ctrl.link_enable))
        else $error("link came up with link control off");
    a_meas_len: assert property ($rose(sample_req) |-> meas_run ##1 !sample_req)
        else $error("measurement run length wrong");
    a_idle_zero: assert property (!take_rd |=> hrdata == 32'h0)
        else $error("read data not cleared outside a read");
endmodule : mon_pcs_props
bind mon_pcs_regs mon_pcs_props mon_pcs_props_inst (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .ipg_active(ipg_active),
    .lock_check_fail(lock_check_fail), .pcs_ctrl(pcs_ctrl), .sample_req(sample_req),
    .link_up(link_up), .lock_lost(lock_lost));
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the monitor and pcs control bank
// assumes mon_pcs_regs is the only slave, its hreadyout fed back as hready
`include "mon_pcs_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        checks++; \
        if ((g) !== (e)) begin \
            error_cnt++; \
            $display("ERROR %s expected %h seen %h", nm, e, g); \
        end \
    end
module testbench;
    import mon_pcs_pkg::*;
    typedef struct {string nm; logic [31:0] exp; logic [31:0] msk;} note_s;
    logic          clk_sys = 1'b0;
    logic          rst = 1'b1;
    logic          hsel = 1'b0;
    logic          hwrite = 1'b0;
    logic [1:0]    htrans = 2'b00;
    logic [31:0]   haddr = '0;
    logic [31:0]   hwdata = '0;
    logic          rd_ph = 1'b0;
    logic          idle_symbol = 1'b0;
    logic          error_symbol = 1'b0;
    logic          ipg_active = 1'b0;
    logic          lock_check_fail = 1'b0;
    sensor_codes_s sensor_raw = '0;
    pcs_control_s  pcs_ctrl;
    logic [31:0]   hrdata;
    logic          hreadyout;
    logic          hresp;
    logic          sample_req;
    logic          link_up;
    logic          lock_lost;
    int            error_cnt = 0;
    int            checks = 0;
    int            waited = 0;
    note_s         notes[$];
    always #5 clk_sys = ~clk_sys;
    mon_pcs_regs mon_pcs_regs_inst (
        .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sensor_raw(sensor_raw),
        .idle_symbol(idle_symbol), .error_symbol(error_symbol), .ipg_active(ipg_active),
        .lock_check_fail(lock_check_fail), .pcs_ctrl(pcs_ctrl), .sample_req(sample_req),
        .link_up(link_up), .lock_lost(lock_lost));
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            $display("ERROR hready expected 1 seen %b", hreadyout);
            give_verdict();
        end
    endtask : wait_rdy
    // one single transfer; a read leaves a note for the monitor, masked by the caller's mask m
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d,
                        input logic [31:0] e, input logic [31:0] m, input string nm);
        note_s t;
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {14'h0, idx, 2'b00};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        t = '{nm, e, m};
        if (!w) notes.push_back(t);
        rd_ph <= !w;
        wait_rdy();
        rd_ph <= 1'b0;
        `CHK("hresp", 1'b0, hresp)
    endtask : xfer
    always @(posedge clk_sys) begin
        note_s t;
        if (rd_ph === 1'b1) begin
            t = notes.pop_front();
            `CHK(t.nm, t.exp, hrdata & t.msk)
        end
    end
    task automatic rd_codes(input sensor_codes_s s);
        xfer(1'b0, `TEMP_STAT_IDX, '0, {29'h0, s.temp_code}, '1, "temperature");
        xfer(1'b0, `SUPPLY_STAT_IDX, '0, {17'h0, s.io_code, 1'b0, s.analog_code, 8'h00},
             '1, "supply");
    endtask : rd_codes
    task automatic wait_sr(input logic lv, input int lim);
        int n;
        n = 0;
        while (sample_req !== lv && n < lim) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        waited = n;
        `CHK("sample_req", lv, sample_req)
        if (sample_req !== lv) give_verdict();
    endtask : wait_sr
    task automatic fail_pulse(input logic ipg, input logic e);
        @(posedge clk_sys);
        ipg_active <= ipg;
        lock_check_fail <= 1'b1;
        @(posedge clk_sys);
        lock_check_fail <= 1'b0;
        #1;
        `CHK("lock_lost", e, lock_lost)
    endtask : fail_pulse
    task automatic pulse_in(input int n, input logic err);
        repeat (n) begin
            @(posedge clk_sys);
            idle_symbol <= !err;
            error_symbol <= err;
            @(posedge clk_sys);
            idle_symbol <= 1'b0;
            error_symbol <= 1'b0;
        end
    endtask : pulse_in
    task automatic link_is(input int wait_cyc, input logic e);
        repeat (wait_cyc) @(posedge clk_sys);
        #1;
        `CHK("link_up", e, link_up)
    endtask : link_is
    initial begin
        sensor_codes_s s;
        logic [8:0]    r;
        void'($urandom(32'h49B0E713));
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        `CHK("pcs_ctrl", {1'b1, 1'b1, `IDLE_CNT_RST}, pcs_ctrl)
        rd_codes('0);
        xfer(1'b0, `PCS_CTRL_IDX, '0, 32'h0000_1078, '1, "pcs_reg");
        xfer(1'b0, `RUN_CFG_IDX, '0, 32'h0000_0002, 32'h0000_0003, "run_cfg");
        xfer(1'b0, 16'h0490, '0, '0, '1, "unmapped");
        xfer(1'b1, `TEMP_STAT_IDX, '1, '0, '0, "");
        xfer(1'b1, `SUPPLY_STAT_IDX, '1, '0, '0, "");
        rd_codes('0);
        $display("test reset_and_read_only done");
        r = 9'($urandom_range(511, 1));
        xfer(1'b1, `PCS_CTRL_IDX, {16'h0, 4'h3, 3'h0, r}, '0, '0, "");
        xfer(1'b0, `PCS_CTRL_IDX, '0, {16'h0, 4'h3, 3'h0, r}, 32'h0000_31FF, "pcs_reg");
        `CHK("pcs_ctrl", {1'b1, 1'b0, r}, pcs_ctrl)
        fail_pulse(1'b1, 1'b0);
        fail_pulse(1'b0, 1'b1);
        xfer(1'b1, `PCS_CTRL_IDX, 32'h0000_1005, '0, '0, "");
        fail_pulse(1'b1, 1'b1);
        $display("test gap_check done");
        pulse_in(4, 1'b0);
        link_is(4, 1'b0);
        pulse_in(1, 1'b0);
        link_is(2, 1'b1);
        xfer(1'b1, `PCS_CTRL_IDX, 32'h0000_0005, '0, '0, "");
        link_is(2, 1'b0);
        xfer(1'b1, `PCS_CTRL_IDX, 32'h0000_1005, '0, '0, "");
        // an error symbol restarts the count, so five fresh idles are needed after it
        pulse_in(4, 1'b0);
        pulse_in(1, 1'b1);
        pulse_in(1, 1'b0);
        link_is(3, 1'b0);
        pulse_in(4, 1'b0);
        link_is(2, 1'b1);
        $display("test idle_lock done");
        s = sensor_codes_s'(9'($urandom));
        sensor_raw <= s;
        xfer(1'b1, `RUN_CFG_IDX, 32'h0000_0001, '0, '0, "");
        wait_sr(1'b1, 20);
        wait_sr(1'b0, 20);
        rd_codes(s);
        xfer(1'b0, `RUN_CFG_IDX, '0, '0, 32'h0000_0003, "run_cfg");
        sensor_raw <= ~s;
        repeat (40) @(posedge clk_sys);
        rd_codes(s);
        $display("test single_run done");
        xfer(1'b1, `RUN_CYCLE_IDX, 32'h0000_0001, '0, '0, "");
        xfer(1'b0, `RUN_CYCLE_IDX, '0, 32'h0000_0001, 32'h0000_000F, "run_cycle");
        xfer(1'b1, `RUN_CFG_IDX, 32'h0000_0003, '0, '0, "");
        wait_sr(1'b1, 20);
        wait_sr(1'b0, 20);
        s = sensor_codes_s'(9'($urandom));
        sensor_raw <= s;
        wait_sr(1'b1, 300);
        // the quiet gap is the programmed period plus the cycle that reloads the timer
        `CHK("wait_gap", 2 * `CYCLE_UNIT_NS / `CLK_PERIOD_NS + 1, waited)
        wait_sr(1'b0, 20);
        rd_codes(s);
        $display("test periodic_run done");
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        `CHK("pcs_ctrl", {1'b1, 1'b1, `IDLE_CNT_RST}, pcs_ctrl)
        xfer(1'b0, `RUN_CYCLE_IDX, '0, '0, 32'h0000_000F, "run_cycle");
        rd_codes('0);
        $display("test mid_reset done");
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
